// [core/nvsr_pkg.sv]
package nvsr_pkg;
  // ***************************************************
  // Geometry
  // ***************************************************
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int MATCH_W = 14;
  // ***************************************************
  // Trigger addresses
  // ***************************************************
  localparam logic [13:0] SEQ_A0 = 14'h0e38;
  localparam logic [13:0] SEQ_A1 = 14'h31c7;
  localparam logic [13:0] SEQ_A2 = 14'h03e0;
  localparam logic [13:0] SEQ_A3 = 14'h3c1f;
  localparam logic [13:0] SEQ_A4 = 14'h303f;
  localparam logic [13:0] SEQ_SAVE = 14'h0fc0;
  localparam logic [13:0] SEQ_RESTORE = 14'h0c63;
  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_NS = 50;
  localparam int ACCESS_NS = 55;
  localparam int PULSE_NS = 45;
  localparam int SAVE_MS = 10;
  localparam int RESTORE_US = 20;
  localparam int POWERUP_US = 550;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAVE_CYC = (SAVE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int RESTORE_CYC = (RESTORE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 24;
  // ***************************************************
  // Operation codes
  // ***************************************************
  typedef enum logic [1:0] {NVSR_READ, NVSR_WRITE, NVSR_SAVE, NVSR_RESTORE} nvsr_op_t;
endpackage

// [core/nvsr_wait.sv]
`timescale 1ns/1ps
module nvsr_wait #(
  parameter int CNT_W = 24
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic done
);
  logic [CNT_W-1:0] count;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (clk_en) begin
      if (load) begin
        count <= load_val;
      end else if (count != '0) begin
        count <= count - 1'b1;
      end
    end
  end
  assign done = (count == '0) && !load;
endmodule

// [core/nvsr_host.sv]
// Operation
// - Reads keep write enable high and writes drive it low.
// - Save is issued as five trigger reads followed by a read of the save address.
// - Restore is issued as five trigger reads followed by a read of the restore address.
// - The six trigger addresses go out in order on consecutive accesses.
// - All six trigger accesses are reads.
// - Each trigger step is one chip-enable pulse with write enable high.
// - No other access is let in between trigger steps.
`timescale 1ns/1ps
module nvsr_host #(
  parameter int SAVE_CYC = nvsr_pkg::SAVE_CYC,
  parameter int RESTORE_CYC = nvsr_pkg::RESTORE_CYC,
  parameter int POWERUP_CYC = nvsr_pkg::POWERUP_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic power_good,
  input wire logic req_valid,
  output logic req_ready,
  input wire nvsr_pkg::nvsr_op_t req_op,
  input wire logic [nvsr_pkg::ADDR_W-1:0] req_addr,
  input wire logic [nvsr_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [nvsr_pkg::DATA_W-1:0] rsp_rdata,
  output logic busy,
  output logic [nvsr_pkg::ADDR_W-1:0] address_in,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n,
  input wire logic [nvsr_pkg::DATA_W-1:0] data_io_in,
  output logic [nvsr_pkg::DATA_W-1:0] data_io_out,
  output logic data_io_oe_n
);
  typedef enum logic [2:0] {ST_POWERUP, ST_IDLE, ST_SETUP, ST_PULSE, ST_GAP, ST_WAIT} nvsr_state_t;

  // ***************************************************
  // Input synchronisers
  // ***************************************************
  logic pg_meta, pg_sync, pg_last;
  logic [nvsr_pkg::DATA_W-1:0] dq_meta, dq_sync;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pg_meta <= 1'b0;
      pg_sync <= 1'b0;
      pg_last <= 1'b0;
      dq_meta <= '0;
      dq_sync <= '0;
    end else if (clk_en) begin
      pg_meta <= power_good;
      pg_sync <= pg_meta;
      pg_last <= pg_sync;
      dq_meta <= data_io_in;
      dq_sync <= dq_meta;
    end
  end
  logic pg_rise, pg_low;
  assign pg_rise = pg_sync && !pg_last;
  assign pg_low = !pg_sync;

  function automatic logic [13:0] seq_addr(input logic [2:0] step, input nvsr_pkg::nvsr_op_t op);
    unique case (step)
      3'h0: seq_addr = nvsr_pkg::SEQ_A0;
      3'h1: seq_addr = nvsr_pkg::SEQ_A1;
      3'h2: seq_addr = nvsr_pkg::SEQ_A2;
      3'h3: seq_addr = nvsr_pkg::SEQ_A3;
      3'h4: seq_addr = nvsr_pkg::SEQ_A4;
      default: seq_addr = (op == nvsr_pkg::NVSR_SAVE) ? nvsr_pkg::SEQ_SAVE : nvsr_pkg::SEQ_RESTORE;
    endcase
  endfunction

  // ***************************************************
  // Sequencer
  // ***************************************************
  nvsr_state_t state;
  nvsr_pkg::nvsr_op_t op;
  logic [2:0] step;
  logic [1:0] phase;
  logic [nvsr_pkg::DATA_W-1:0] wdata;
  logic wait_load, wait_done;
  logic [nvsr_pkg::CNT_W-1:0] wait_val;
  logic is_seq, last_step;
  assign is_seq = (op == nvsr_pkg::NVSR_SAVE) || (op == nvsr_pkg::NVSR_RESTORE);
  assign last_step = !is_seq || (step == 3'h5);
  assign req_ready = (state == ST_IDLE) && pg_sync;
  assign busy = (state != ST_IDLE);

  always_comb begin
    wait_load = 1'b0;
    wait_val = nvsr_pkg::CNT_W'(POWERUP_CYC);
    if (pg_rise) begin
      wait_load = 1'b1;
    end else if (state == ST_GAP && phase == 2'd0 && last_step && is_seq) begin
      wait_load = 1'b1;
      wait_val = (op == nvsr_pkg::NVSR_SAVE) ? nvsr_pkg::CNT_W'(SAVE_CYC) : nvsr_pkg::CNT_W'(RESTORE_CYC);
    end
  end

  nvsr_wait #(.CNT_W(nvsr_pkg::CNT_W)) u_wait (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .load(wait_load),
    .load_val(wait_val),
    .done(wait_done)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_POWERUP;
      op <= nvsr_pkg::NVSR_READ;
      step <= 3'h0;
      phase <= 2'd0;
      wdata <= '0;
      address_in <= '0;
    end else if (clk_en) begin
      if (pg_low) begin
        state <= ST_POWERUP;
      end else begin
        unique case (state)
          ST_POWERUP: if (wait_done && !pg_rise) state <= ST_IDLE;
          ST_IDLE: if (req_valid) begin
            op <= req_op;
            step <= 3'h0;
            wdata <= req_wdata;
            if (req_op == nvsr_pkg::NVSR_SAVE || req_op == nvsr_pkg::NVSR_RESTORE) begin
              address_in <= {1'b0, seq_addr(3'h0, req_op)};
            end else begin
              address_in <= req_addr;
            end
            state <= ST_SETUP;
          end
          ST_SETUP: begin
            phase <= 2'd0;
            state <= ST_PULSE;
          end
          ST_PULSE: begin
            if (phase == 2'(nvsr_pkg::ACCESS_CYC)) begin
              phase <= 2'd0;
              state <= ST_GAP;
            end else begin
              phase <= phase + 2'd1;
            end
          end
          ST_GAP: begin
            if (last_step) begin
              state <= is_seq ? ST_WAIT : ST_IDLE;
            end else begin
              step <= step + 3'h1;
              address_in <= {1'b0, seq_addr(step + 3'h1, op)};
              state <= ST_SETUP;
            end
          end
          ST_WAIT: if (wait_done) state <= ST_IDLE;
          default: state <= ST_POWERUP;
        endcase
      end
    end
  end

  // ***************************************************
  // Pin drive
  // ***************************************************
  logic writing;
  assign writing = (op == nvsr_pkg::NVSR_WRITE);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chip_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      data_io_oe_n <= 1'b1;
      data_io_out <= '0;
    end else if (clk_en) begin
      // one chip-enable pulse per access
      // Chip enable lags one cycle so write enable is settled before it falls
      chip_enable_n <= !(state == ST_PULSE && phase != 2'(nvsr_pkg::ACCESS_CYC));
      // write enable only for writes, set before chip enable
      write_enable_n <= !(writing && (state == ST_SETUP || (state == ST_PULSE && phase != 2'(nvsr_pkg::ACCESS_CYC))));
      output_enable_n <= !(!writing && (state == ST_SETUP || state == ST_PULSE) && phase != 2'(nvsr_pkg::ACCESS_CYC));
      data_io_oe_n <= !(writing && (state == ST_SETUP || state == ST_PULSE));
      data_io_out <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else if (clk_en) begin
      rsp_valid <= (state == ST_GAP) && last_step && !is_seq;
      if (state == ST_GAP && !writing) rsp_rdata <= dq_sync;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  property p_rd_we_high;
    @(posedge core_clk) disable iff (!arst_n) (!chip_enable_n && !writing) |-> write_enable_n;
  endproperty
  a_rd_we_high: assert property (p_rd_we_high) else $error("write enable low on read");
  property p_wr_no_drive;
    @(posedge core_clk) disable iff (!arst_n) $fell(chip_enable_n) && writing |-> !write_enable_n && !$past(write_enable_n);
  endproperty
  a_wr_no_drive: assert property (p_wr_no_drive) else $error("write enable late");
  property p_bit14;
    @(posedge core_clk) disable iff (!arst_n) (is_seq && !chip_enable_n) |-> !address_in[14];
  endproperty
  a_bit14: assert property (p_bit14) else $error("trigger bit 14 set");
  property p_seq_we;
    @(posedge core_clk) disable iff (!arst_n) (is_seq && busy && state != ST_POWERUP) |-> write_enable_n;
  endproperty
  a_seq_we: assert property (p_seq_we) else $error("write inside trigger");
  property p_wait_quiet;
    @(posedge core_clk) disable iff (!arst_n) $past(state == ST_WAIT) && state == ST_WAIT |-> chip_enable_n;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("access during transfer");
  sequence s_sixth;
    state == ST_GAP && is_seq && step == 3'h5;
  endsequence
  property p_save_hold;
    @(posedge core_clk) disable iff (!arst_n || !pg_sync) s_sixth ##1 clk_en |-> ##1 busy [*8];
  endproperty
  a_save_hold: assert property (p_save_hold) else $error("transfer wait too short");
  property p_order;
    @(posedge core_clk) disable iff (!arst_n) (state == ST_GAP && is_seq && step != 3'h5 && clk_en && pg_sync)
      |=> step == $past(step) + 3'h1;
  endproperty
  a_order: assert property (p_order) else $error("trigger order broken");
  property p_no_gap;
    @(posedge core_clk) disable iff (!arst_n) (state == ST_GAP && is_seq && !last_step && clk_en && pg_sync)
      |=> (state == ST_SETUP) && (address_in[13:0] == seq_addr(step, op));
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("request taken mid sequence");
  property p_pwr;
    @(posedge core_clk) disable iff (!arst_n) pg_rise |=> !req_ready;
  endproperty
  a_pwr: assert property (p_pwr) else $error("ready during power-up restore");
endmodule

// [tb/nvsr_dev_model.sv]
`timescale 1ns/1ps
module nvsr_dev_model #(
  parameter int SAVE_NS = 900,
  parameter int RESTORE_NS = 450,
  parameter int POWERUP_NS = 1400
) (
  input wire logic power_good,
  input wire logic [14:0] address_in,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [7:0] data_io_out,
  input wire logic data_io_oe_n,
  output logic [7:0] data_io_in,
  output int saves,
  output int restores,
  output int faults
);
  logic [7:0] mem [0:32767];
  logic [7:0] shadow [0:32767];
  logic [13:0] seq [0:4] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
  int step = 0;
  logic busy = 1'b0;
  logic wr_at_sel = 1'b0;
  logic [7:0] park = 8'h5a;
  logic drv;
  initial begin
    saves = 0;
    restores = 0;
    faults = 0;
  end
  task automatic go(input int ns);
    busy = 1'b1;
    #ns;
    busy = 1'b0;
  endtask
  // drive only on reads begun as reads
  assign drv = !chip_enable_n && !output_enable_n && write_enable_n && !wr_at_sel && !busy;
  assign data_io_in = drv ? mem[address_in] : park;
  // Released bus shows the inverse so a stale byte never passes
  always @(negedge drv) park = ~mem[address_in];
  always @* begin
    if (!chip_enable_n && !write_enable_n && !busy && !data_io_oe_n) mem[address_in] = data_io_out;
    if (drv && !data_io_oe_n) faults++;
  end
  // ordered reads on low 14 bits
  always @(negedge chip_enable_n) begin
    wr_at_sel = !write_enable_n;
    if (busy || !power_good) faults++;
    else if (wr_at_sel) step = 0;
    else if (step == 5 && address_in[13:0] == 14'h0fc0) begin
      saves++;
      step = 0;
      shadow = mem;
      fork go(SAVE_NS); join_none
    end else if (step == 5 && address_in[13:0] == 14'h0c63) begin
      restores++;
      step = 0;
      mem = shadow;
      fork go(RESTORE_NS); join_none
    end else if (step < 5 && address_in[13:0] == seq[step]) step++;
    else step = (address_in[13:0] == seq[0]) ? 1 : 0;
  end
  always @(posedge power_good) begin
    mem = shadow;
    fork go(POWERUP_NS); join_none
  end
endmodule

// [tb/tb_nvsr_host.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module tb_nvsr_host;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic power_good = 1'b0;
  logic req_valid = 1'b0;
  nvsr_pkg::nvsr_op_t req_op = nvsr_pkg::NVSR_READ;
  logic [14:0] req_addr = 15'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, busy, chip_enable_n, output_enable_n, write_enable_n, data_io_oe_n;
  logic [7:0] rsp_rdata, data_io_in, data_io_out;
  logic [14:0] address_in;
  int saves, restores, faults;
  int err_count = 0;
  int num_checks = 0;
  // ***************************************************
  // Instances
  // ***************************************************
  // Short waits keep the run brief; the model's busy spans sit just inside them
  nvsr_host #(.SAVE_CYC(20), .RESTORE_CYC(10), .POWERUP_CYC(30)) i_nvsr_host (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1), .power_good(power_good),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy),
    .address_in(address_in), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .data_io_in(data_io_in), .data_io_out(data_io_out),
    .data_io_oe_n(data_io_oe_n));
  nvsr_dev_model i_nvsr_dev_model (
    .power_good(power_good), .address_in(address_in), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .data_io_out(data_io_out),
    .data_io_oe_n(data_io_oe_n), .data_io_in(data_io_in), .saves(saves), .restores(restores),
    .faults(faults));
  initial forever #25 core_clk = ~core_clk;
  // ***************************************************
  // Tasks
  // ***************************************************
  task automatic req(input nvsr_pkg::nvsr_op_t op, input logic [14:0] a, input logic [7:0] d = 8'h00);
    int n;
    n = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= d;
    do @(negedge core_clk); while (req_ready !== 1'b1 && ++n < 2000);
    if (n >= 2000) err_count++;
    @(posedge core_clk);
    req_valid <= 1'b0;
    n = 0;
    if (op == nvsr_pkg::NVSR_READ || op == nvsr_pkg::NVSR_WRITE) begin
      do @(negedge core_clk); while (rsp_valid !== 1'b1 && ++n < 100);
      if (n >= 100) err_count++;
    end else begin
      do @(negedge core_clk); while (busy !== 1'b0 && ++n < 2000);
      if (n >= 2000) err_count++;
    end
  endtask
  task automatic t_rw();
    req(nvsr_pkg::NVSR_WRITE, 15'h4123, 8'hc3);
    req(nvsr_pkg::NVSR_WRITE, 15'h0123, 8'h3c);
    req(nvsr_pkg::NVSR_READ, 15'h4123);
    `CHK(rsp_rdata, 8'hc3)
    req(nvsr_pkg::NVSR_READ, 15'h0123);
    `CHK(rsp_rdata, 8'h3c)
    $display("test rw done");
  endtask
  task automatic t_save_restore();
    req(nvsr_pkg::NVSR_SAVE, 15'h0000, 8'h00);
    `CHK(saves, 1)
    req(nvsr_pkg::NVSR_WRITE, 15'h4123, 8'h00);
    req(nvsr_pkg::NVSR_RESTORE, 15'h0000, 8'h00);
    `CHK(restores, 1)
    req(nvsr_pkg::NVSR_READ, 15'h4123);
    `CHK(rsp_rdata, 8'hc3)
    `CHK(faults, 0)
    $display("test save restore done");
  endtask
  task automatic t_power();
    int n;
    req(nvsr_pkg::NVSR_WRITE, 15'h4123, 8'h77);
    @(posedge core_clk);
    power_good <= 1'b0;
    repeat (5) @(posedge core_clk);
    `CHK(req_ready, 1'b0)
    power_good <= 1'b1;
    repeat (25) @(posedge core_clk);
    `CHK(req_ready, 1'b0)
    n = 0;
    do @(negedge core_clk); while (req_ready !== 1'b1 && ++n < 100);
    `CHK(req_ready, 1'b1)
    req(nvsr_pkg::NVSR_READ, 15'h4123);
    `CHK(rsp_rdata, 8'hc3)
    `CHK(faults, 0)
    $display("test power done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ***************************************************
  // Sequence
  // ***************************************************
  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    power_good <= 1'b1;
    t_rw();
    t_save_restore();
    t_power();
    results();
  end
  initial begin
    #1000000;
    err_count++;
    results();
  end
endmodule
